/* File: inc/wake_timer_consts.svh */
`ifndef WAKE_TIMER_CONSTS_SVH
`define WAKE_TIMER_CONSTS_SVH

// Register addresses on the special function register port
`define ADDR_WAKE_IRQ_CONTROL 8'hA1
`define ADDR_SLEEP_TIMER_CONTROL 8'hA2
`define ADDR_EVENT_TIMEOUT_LOW 8'hA3
`define ADDR_EVENT_TIMEOUT_HIGH 8'hA4
`define ADDR_COUNT_VALUE_LOW 8'hA5
`define ADDR_COUNT_VALUE_HIGH 8'hA6

// Reset values
`define RST_EVENT_TIMEOUT_LOW 8'h6B
`define RST_EVENT_TIMEOUT_HIGH 8'h87
`define RST_COUNT_BYTE 8'h00
`define RST_CTRL_RESERVED 3'h7
`define TIMER_RESET_VALUE 31'h0000_0004

// Field positions
`define CTRL_RES_LSB 0
`define CTRL_TIMER_RESET_BIT 2
`define CTRL_RESERVED_LSB 4
`define IRQC_FLAG_BIT 0
`define IRQC_RSVD1_BIT 1
`define IRQC_RSVD5_BIT 5
`define IRQC_MASK_BIT 4

// Slice step per resolution setting
`define RES_SHIFT_STEP 5

`endif

/* File: inc/wake_timer_pkg.sv */
package wake_timer_pkg;

  // Register bus request from the CPU special function register port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // Resolution selection
  typedef enum logic [1:0] {
    RES_1 = 2'h0,
    RES_32 = 2'h1,
    RES_1K = 2'h2,
    RES_32K = 2'h3
  } resolution_t;

endpackage

/* File: logic/sleep_wakeup_timer.sv */
// Contract
// - Wake event sets the local pending flag in the interrupt control register.
// - Pending flag with mask set also raises the CPU-level wake interrupt flag.
// - CPU flag raised while CPU enable is 1 issues an interrupt request.
// - Interrupt request is suppressed when sleep mode field is not 00.
// - Address A5 reads low byte of the resolution-selected counter slice.
// - Address A6 reads high byte of that slice; both reset to 00.
// - Event value high byte read/write at A4, reset 87.
// - Event value low byte read/write at A3, reset 6B.
// - Writing 1 to timer reset bit loads counter with 4; bit reads 0.
// - Resolution 00,01,10,11 selects bits 15:0, 20:5, 25:10, 30:15.
// - Changing resolution only moves the slice; the counter keeps running.
// - Event interval is event value times 2^(5*res) slow clock periods.
// - In power modes zero to two the wake event returns chip to active.
`timescale 1ns/100ps
`include "wake_timer_consts.svh"

module sleep_wakeup_timer (
  input wire logic clk, // System clock, 100 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire wake_timer_pkg::sfr_req_t sfr_req, // CPU register access
  output logic [7:0] sfr_rdata, // Read data, registered
  input wire logic slow_clk_pin, // Slow clock from crystal or RC oscillator
  input wire logic [1:0] sleep_mode, // Power mode field, 00 is active
  input wire logic cpu_wake_irq_enable, // CPU-level interrupt enable
  input wire logic cpu_flag_clear, // CPU clears its flag, one-cycle pulse
  output logic cpu_wake_irq_flag, // CPU-level wake interrupt flag
  output logic wake_interrupt, // Interrupt request to CPU
  output logic wake_to_active // Wake request to power controller, pulse
);

  // Slice select shared by readback and compare
  function automatic logic [15:0] slice_of(input logic [30:0] cnt, input logic [1:0] res);
    logic [30:0] sh;
    sh = cnt >> (res * `RES_SHIFT_STEP);
    slice_of = sh[15:0];
  endfunction

  // Write strobe for one register address
  function automatic logic write_hit(
    input wake_timer_pkg::sfr_req_t req,
    input logic [7:0] addr
  );
    write_hit = req.wr && (req.addr == addr);
  endfunction

  logic [30:0] count_reg;
  logic [30:0] count_next;
  logic [7:0] evt_low_reg;
  logic [7:0] evt_high_reg;
  logic [1:0] res_reg;
  logic [2:0] ctrl_rsvd_reg;
  logic irqc_mask_reg;
  logic irqc_rsvd5_reg;
  logic irqc_rsvd1_reg;
  logic pending_reg;
  logic cpu_flag_reg;
  logic irq_reg;
  logic wake_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic sync1_reg;
  logic sync2_reg;
  logic slow_prev_reg;
  logic reset_req_reg;

  // Decode of register writes
  wire logic wr_ctrl = write_hit(sfr_req, `ADDR_SLEEP_TIMER_CONTROL);
  wire logic wr_evt_lo = write_hit(sfr_req, `ADDR_EVENT_TIMEOUT_LOW);
  wire logic wr_evt_hi = write_hit(sfr_req, `ADDR_EVENT_TIMEOUT_HIGH);
  wire logic wr_irqc = write_hit(sfr_req, `ADDR_WAKE_IRQ_CONTROL);
  wire logic timer_reset_wr = wr_ctrl && sfr_req.wdata[`CTRL_TIMER_RESET_BIT];

  // Write-zero clears of the interrupt control flag bits
  wire logic pending_clear_wr = wr_irqc && !sfr_req.wdata[`IRQC_FLAG_BIT];
  wire logic rsvd1_clear_wr = wr_irqc && !sfr_req.wdata[`IRQC_RSVD1_BIT];

  // Slow clock edge, seen only through the second synchroniser stage
  wire logic slow_tick = sync2_reg && !slow_prev_reg;

  // Counter step, the slice shown to software and the slice the step lands on
  wire logic [30:0] count_inc = count_reg + 31'h0000_0001;
  wire logic [15:0] slice = slice_of(count_reg, res_reg);
  wire logic [15:0] slice_inc = slice_of(count_inc, res_reg);
  wire logic [15:0] event_value = {evt_high_reg, evt_low_reg};

  // Event on the slow edge that brings the slice to the value; a pending reset wins
  wire logic match_now = (slice_inc == event_value);
  wire logic wake_event = slow_tick && match_now && !reset_req_reg;
  wire logic flag_set = wake_event;

  // Power mode qualifiers
  wire logic mode_active = (sleep_mode == 2'h0);
  wire logic mode_wakeable = (sleep_mode != 2'h3);

  // CPU-level flag set, interrupt request raise and drop conditions
  wire logic cpu_flag_set = flag_set && irqc_mask_reg;
  wire logic irq_set = cpu_flag_set && cpu_wake_irq_enable && mode_active;
  wire logic irq_drop = cpu_flag_clear || !cpu_wake_irq_enable || !mode_active;

  // Read views of the control and interrupt control registers
  wire logic [7:0] irqc_view =
    {2'h0, irqc_rsvd5_reg, irqc_mask_reg, 2'h0, irqc_rsvd1_reg, pending_reg};
  wire logic [7:0] ctrl_view = {1'b0, ctrl_rsvd_reg, 2'h0, res_reg};

  // Counter next value: timer reset on the next slow edge, restart at the event
  always_comb begin
    count_next = count_reg;
    if (slow_tick) begin
      if (reset_req_reg) begin
        count_next = `TIMER_RESET_VALUE;
      end else if (match_now) begin
        count_next = 31'h0000_0000;
      end else begin
        count_next = count_inc;
      end
    end
  end

  // Two-stage synchroniser for the slow clock pin
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= slow_clk_pin;
      sync2_reg <= sync1_reg;
    end
  end

  // Previous synchronised level for the edge detect
  always_ff @(posedge clk) begin
    if (rst) begin
      slow_prev_reg <= 1'b0;
    end else begin
      slow_prev_reg <= sync2_reg;
    end
  end

  // Sleep counter
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 31'h0000_0000;
    end else begin
      count_reg <= count_next;
    end
  end

  // Timer reset request, held until the next slow edge applies it
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_req_reg <= 1'b0;
    end else if (timer_reset_wr) begin
      reset_req_reg <= 1'b1;
    end else if (slow_tick) begin
      reset_req_reg <= 1'b0;
    end
  end

  // Event timeout low byte
  always_ff @(posedge clk) begin
    if (rst) begin
      evt_low_reg <= `RST_EVENT_TIMEOUT_LOW;
    end else if (wr_evt_lo) begin
      evt_low_reg <= sfr_req.wdata;
    end
  end

  // Event timeout high byte
  always_ff @(posedge clk) begin
    if (rst) begin
      evt_high_reg <= `RST_EVENT_TIMEOUT_HIGH;
    end else if (wr_evt_hi) begin
      evt_high_reg <= sfr_req.wdata;
    end
  end

  // Resolution field
  always_ff @(posedge clk) begin
    if (rst) begin
      res_reg <= wake_timer_pkg::RES_1;
    end else if (wr_ctrl) begin
      res_reg <= sfr_req.wdata[`CTRL_RES_LSB +: 2];
    end
  end

  // Reserved control field
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_rsvd_reg <= `RST_CTRL_RESERVED;
    end else if (wr_ctrl) begin
      ctrl_rsvd_reg <= sfr_req.wdata[`CTRL_RESERVED_LSB +: 3];
    end
  end

  // Event interrupt mask
  always_ff @(posedge clk) begin
    if (rst) begin
      irqc_mask_reg <= 1'b0;
    end else if (wr_irqc) begin
      irqc_mask_reg <= sfr_req.wdata[`IRQC_MASK_BIT];
    end
  end

  // Plain reserved bit of the interrupt control register
  always_ff @(posedge clk) begin
    if (rst) begin
      irqc_rsvd5_reg <= 1'b0;
    end else if (wr_irqc) begin
      irqc_rsvd5_reg <= sfr_req.wdata[`IRQC_RSVD5_BIT];
    end
  end

  // Pending flag: write 0 clears, event set wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      pending_reg <= 1'b0;
    end else if (flag_set) begin
      pending_reg <= 1'b1;
    end else if (pending_clear_wr) begin
      pending_reg <= 1'b0;
    end
  end

  // Reserved write-zero bit: software can only clear it
  always_ff @(posedge clk) begin
    if (rst) begin
      irqc_rsvd1_reg <= 1'b0;
    end else if (rsvd1_clear_wr) begin
      irqc_rsvd1_reg <= 1'b0;
    end
  end

  // CPU-level flag: set wins over the clear pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_flag_reg <= 1'b0;
    end else if (cpu_flag_set) begin
      cpu_flag_reg <= 1'b1;
    end else if (cpu_flag_clear) begin
      cpu_flag_reg <= 1'b0;
    end
  end

  // Interrupt request: raised with the flag, dropped outside mode 00
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else if (irq_set) begin
      irq_reg <= 1'b1;
    end else if (irq_drop) begin
      irq_reg <= 1'b0;
    end
  end

  // Wake pulse to the power controller
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= wake_event && mode_wakeable;
    end
  end

  // Read data mux
  always_comb begin
    rdata_next = 8'h00;
    unique case (sfr_req.addr)
      `ADDR_WAKE_IRQ_CONTROL: begin
        rdata_next = irqc_view;
      end
      `ADDR_SLEEP_TIMER_CONTROL: begin
        rdata_next = ctrl_view;
      end
      `ADDR_EVENT_TIMEOUT_LOW: begin
        rdata_next = evt_low_reg;
      end
      `ADDR_EVENT_TIMEOUT_HIGH: begin
        rdata_next = evt_high_reg;
      end
      `ADDR_COUNT_VALUE_LOW: begin
        rdata_next = slice[7:0];
      end
      `ADDR_COUNT_VALUE_HIGH: begin
        rdata_next = slice[15:8];
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  // Registered read data
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= `RST_COUNT_BYTE;
    end else if (sfr_req.rd) begin
      rdata_reg <= rdata_next;
    end
  end

  assign sfr_rdata = rdata_reg;
  assign cpu_wake_irq_flag = cpu_flag_reg;
  assign wake_interrupt = irq_reg;
  assign wake_to_active = wake_reg;

endmodule

/* File: bench/sleep_wakeup_timer_assertions.sv */
`timescale 1ns/100ps
module sleep_wakeup_timer_assertions (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire wake_timer_pkg::sfr_req_t sfr_req, // Bus request
  input wire logic [7:0] sfr_rdata, // Read data
  input wire logic [1:0] sleep_mode, // Power mode
  input wire logic cpu_wake_irq_enable, // CPU enable
  input wire logic cpu_flag_clear, // CPU clear
  input wire logic cpu_wake_irq_flag, // CPU flag
  input wire logic wake_interrupt, // Request
  input wire logic wake_to_active // Wake pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Bus, flag and request relations
  property p_irq_mode; sleep_mode != 2'h0 |=> !wake_interrupt; endproperty
  a_irq_mode: assert property (p_irq_mode) else $error("request while asleep");
  property p_irq_flag; wake_interrupt |-> cpu_wake_irq_flag; endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("request without flag");
  property p_irq_en; !cpu_wake_irq_enable |=> !wake_interrupt; endproperty
  a_irq_en: assert property (p_irq_en) else $error("request while disabled");
  property p_irq_rise;
    $rose(wake_interrupt) |-> $past(cpu_wake_irq_enable) && $past(sleep_mode) == 2'h0;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("request raised wrongly");
  property p_clear; cpu_flag_clear |=> !cpu_wake_irq_flag ##0 !wake_interrupt; endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_hold; !sfr_req.rd |=> $stable(sfr_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rst_bit; sfr_req.rd && sfr_req.addr == 8'hA2 |=> !sfr_rdata[2]; endproperty
  a_rst_bit: assert property (p_rst_bit) else $error("reset bit read as one");
  property p_pulse; wake_to_active |=> !wake_to_active; endproperty
  a_pulse: assert property (p_pulse) else $error("wake pulse too long");
  cover property ($rose(wake_interrupt));
  cover property ($rose(cpu_wake_irq_flag) && sleep_mode != 2'h0);
  cover property (sfr_req.rd && sfr_req.addr == 8'hA2);
endmodule
bind sleep_wakeup_timer sleep_wakeup_timer_assertions u_chk (.clk, .rst, .sfr_req, .sfr_rdata,
  .sleep_mode, .cpu_wake_irq_enable, .cpu_flag_clear, .cpu_wake_irq_flag, .wake_interrupt,
  .wake_to_active);

/* File: bench/sleep_wakeup_timer_tb.sv */
`timescale 1ns/100ps
module sleep_wakeup_timer_tb;
  logic clk = 0, rst = 1, slow = 0, en = 1, clr = 0;
  logic [1:0] mode = 2'h0;
  wake_timer_pkg::sfr_req_t req = '0;
  logic [7:0] rdata;
  logic irq_flag, irq, wake;
  int miscompares = 0, comparisons = 0;
  logic [7:0] wakes = 8'h00;
  always #5 clk = ~clk;
  sleep_wakeup_timer u_dut (.clk(clk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata),
    .slow_clk_pin(slow), .sleep_mode(mode), .cpu_wake_irq_enable(en),
    .cpu_flag_clear(clr), .cpu_wake_irq_flag(irq_flag), .wake_interrupt(irq),
    .wake_to_active(wake));
  // Count wake pulses half a cycle after they are launched
  always @(negedge clk) if (wake === 1'b1) wakes <= wakes + 8'h01;
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) req = '{1'b1, 1'b0, a, d};
    @(negedge clk) req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk) req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk) req = '0;
    @(negedge clk) check(rdata, exp);
  endtask
  // Slow clock pulses, each one counter step
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk) slow = 1;
      repeat (4) @(negedge clk);
      slow = 0;
      repeat (4) @(negedge clk);
    end
  endtask
  task automatic clear_cpu;
    @(negedge clk) clr = 1;
    @(negedge clk) clr = 0;
  endtask
  task automatic final_report;
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    final_report;
  end
  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    rd(8'hA3, 8'h6B);
    rd(8'hA4, 8'h87);
    rd(8'hA5, 8'h00);
    rd(8'hA6, 8'h00);
    rd(8'hA2, 8'h70);
    rd(8'hA7, 8'h00);
    wr(8'hA4, 8'h00);
    wr(8'hA3, 8'h03);
    rd(8'hA3, 8'h03);
    rd(8'hA4, 8'h00);
    wr(8'hA1, 8'h10);
    tick(3);
    rd(8'hA5, 8'h00);
    rd(8'hA1, 8'h11);
    check({7'h00, irq_flag}, 8'h01);
    check({7'h00, irq}, 8'h01);
    wr(8'hA1, 8'h10);
    clear_cpu;
    rd(8'hA1, 8'h10);
    mode = 2'h1;
    wr(8'hA3, 8'h05);
    tick(5);
    check({7'h00, irq_flag}, 8'h01);
    check({7'h00, irq}, 8'h00);
    check(wakes, 8'h02);
    clear_cpu;
    mode = 2'h0;
    wr(8'hA3, 8'h40);
    wr(8'hA2, 8'h04);
    rd(8'hA2, 8'h00);
    tick(1);
    rd(8'hA5, 8'h04);
    tick(1);
    rd(8'hA5, 8'h05);
    wr(8'hA2, 8'h01);
    tick(27);
    rd(8'hA5, 8'h01);
    rd(8'hA6, 8'h00);
    wr(8'hA2, 8'h00);
    rd(8'hA5, 8'h20);
    mode = 2'h3;
    tick(31);
    check({7'h00, irq_flag}, 8'h00);
    tick(1);
    check({7'h00, irq_flag}, 8'h01);
    check({7'h00, irq}, 8'h00);
    check(wakes, 8'h02);
    rd(8'hA5, 8'h00);
    final_report;
  end
endmodule
